// [adsc_device.sv]
// Converter end: edge counting, hold/track, output drive and power modes
// Overview of operation
// - Select fall: hold, sample, drive, start
// - Serial clock alone paces conversion and shifting
// - Host gives at least 16 clocks
// - Track again at rise after 15 falls
// - Output released on 16th fall
// - Early select rise aborts, releases output
// - First zero driven by select fall
// - Each fall shifts out next bit
// - Two zeros then 14 bits, MSB first
// - Last bit driven on 15th fall
// - Rising-edge capture host option
// - Eight-clock burst requests power-down
// - Host spaces frames by whole periods
// - Rise between 2nd and 10th: power-down
// - Rise between 10th and 16th: stays up
// - Wake only past 10th fall; dummy frame
// - Host waits quiet time before select
`timescale 1ns/1ps
module adsc_device #(
  parameter int RESULT_W = adsc_pkg::RESULT_BITS
) (
  input wire logic clock,
  input wire logic rst,
  adsc_if.device link,
  input wire logic [RESULT_W-1:0] analog_code,
  output logic track_hold,
  output logic powered_down,
  output logic conv_valid,
  output logic [RESULT_W-1:0] conv_result
);
  // ----------------------------------------------------------------
  // Three-stage pin samplers
  // ----------------------------------------------------------------
  logic [2:0] sel_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic sel_reg;
  logic sclk_reg;

  always_ff @(posedge clock) begin
    sel_sync_reg <= {sel_sync_reg[1:0], link.select_n};
    sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
  end

  // Filtered levels change once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      sel_reg <= 1'b1;
      sclk_reg <= 1'b1; // Idle level of the serial clock, no false edge
    end else begin
      if (sel_sync_reg[1] == sel_sync_reg[2]) sel_reg <= sel_sync_reg[2];
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_reg <= sclk_sync_reg[2];
    end
  end

  wire sel_new = (sel_sync_reg[1] == sel_sync_reg[2]) ? sel_sync_reg[2] : sel_reg;
  wire sclk_new = (sclk_sync_reg[1] == sclk_sync_reg[2]) ? sclk_sync_reg[2] : sclk_reg;
  wire sel_fall = sel_reg && !sel_new;
  wire sel_rise = !sel_reg && sel_new;
  wire sclk_fall = sclk_reg && !sclk_new && !sel_new;
  wire sclk_rise = !sclk_reg && sclk_new && !sel_new;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  logic [4:0] edge_cnt_reg;
  logic [15:0] shift_reg;
  logic oe_reg;
  logic hold_reg;
  logic pd_reg;
  logic waking_reg;
  logic valid_reg;
  logic [RESULT_W-1:0] result_reg;
  logic [RESULT_W-1:0] sample_reg;

  wire [4:0] cnt_inc = edge_cnt_reg + 5'h01;
  wire rise_early = sel_rise && edge_cnt_reg < adsc_pkg::DONE_EDGE;
  wire rise_pd_win = sel_rise && edge_cnt_reg >= adsc_pkg::PD_ENTER_MIN && edge_cnt_reg < adsc_pkg::PWR_KEEP_MIN;
  wire rise_keep = sel_rise && edge_cnt_reg >= adsc_pkg::PWR_KEEP_MIN;
  wire wake_fall = sclk_fall && pd_reg && cnt_inc == adsc_pkg::PWR_KEEP_MIN;

  // Falling-edge counter, cleared while select is high
  always_ff @(posedge clock) begin
    if (rst || sel_new) begin
      edge_cnt_reg <= 5'h00;
    end else if (sel_fall) begin
      edge_cnt_reg <= 5'h00;
    end else if (sclk_fall && edge_cnt_reg != 5'h1f) begin
      edge_cnt_reg <= cnt_inc;
    end
  end

  // Output shifter: zero on select fall, next bit each fall
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_reg <= 16'h0000;
      sample_reg <= '0;
    end else if (sel_fall) begin
      shift_reg <= {2'b00, analog_code};
      sample_reg <= analog_code;
    end else if (sclk_fall) begin
      shift_reg <= {shift_reg[14:0], 1'b0};
    end
  end

  // Output enable
  always_ff @(posedge clock) begin
    if (rst) begin
      oe_reg <= 1'b0;
    end else if (sel_fall) begin
      oe_reg <= 1'b1;
    end else if (sel_rise && rise_early) begin
      oe_reg <= 1'b0;
    end else if (sclk_fall && cnt_inc == adsc_pkg::DONE_EDGE) begin
      oe_reg <= 1'b0;
    end
  end

  // Track-and-hold: hold on select fall, track after 15 falls
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else if (sel_fall) begin
      hold_reg <= 1'b1;
    end else if (sel_rise) begin
      hold_reg <= 1'b0;
    end else if (sclk_rise && edge_cnt_reg >= adsc_pkg::TRACK_EDGE) begin
      hold_reg <= 1'b0;
    end
  end

  // Power mode taken from the count at select rise
  always_ff @(posedge clock) begin
    if (rst) begin
      pd_reg <= 1'b0;
      waking_reg <= 1'b0;
    end else begin
      if (rise_pd_win) begin
        pd_reg <= 1'b1;
      end else if (wake_fall) begin
        pd_reg <= 1'b0;
      end
      if (wake_fall) begin
        waking_reg <= 1'b1;
      end else if (sel_fall) begin
        waking_reg <= 1'b0;
      end
    end
  end

  // Result capture: only a full frame from a powered part counts
  always_ff @(posedge clock) begin
    if (rst) begin
      valid_reg <= 1'b0;
      result_reg <= '0;
    end else begin
      valid_reg <= 1'b0;
      if (sclk_fall && cnt_inc == adsc_pkg::DONE_EDGE && !pd_reg && !waking_reg) begin
        valid_reg <= 1'b1;
        result_reg <= sample_reg; // Shifter has emptied by now
      end
    end
  end

  // Rise in the late window keeps power; nothing else to do
  wire keep_power = rise_keep && !pd_reg;

  assign link.serial_data_out = shift_reg[15];
  assign link.serial_data_oe = oe_reg;
  assign track_hold = hold_reg;
  assign powered_down = pd_reg && !keep_power;
  assign conv_valid = valid_reg;
  assign conv_result = result_reg;
endmodule

// [adsc_pkg.sv]
// Package of shared constants and types for the serial converter link
package adsc_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int RESULT_BITS = 14;
  localparam int LEAD_ZEROS = 2;

  // ----------------------------------------------------------------
  // Edge-count thresholds for select rise, return to track and burst lengths
  // ----------------------------------------------------------------
  localparam logic [4:0] PD_ENTER_MIN = 5'h02;
  localparam logic [4:0] PWR_KEEP_MIN = 5'h0a;
  localparam logic [4:0] TRACK_EDGE = 5'h0f;
  localparam logic [4:0] DONE_EDGE = 5'h10;
  localparam logic [4:0] SHORT_BURST = 5'h08;

  // ----------------------------------------------------------------
  // Host timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int QUIET_NS = 400;
  localparam int QUIET_CYCLES = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = 4;
  localparam int SAMPLE_PERIOD_SCLK = 20;

  // ----------------------------------------------------------------
  // Host states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    HST_IDLE  = 5'b00001,
    HST_LOW   = 5'b00010,
    HST_HIGH  = 5'b00100,
    HST_END   = 5'b01000,
    HST_QUIET = 5'b10000
  } adsc_host_state_t;

endpackage

// [adsc_if.sv]
// Interface joining the converter end and the host end
`timescale 1ns/1ps
interface adsc_if;
  logic select_n;
  logic sclk;
  logic serial_data_out;
  logic serial_data_oe;
  wire serial_data_out_wire = serial_data_oe ? serial_data_out : 1'b1;

  modport device (input select_n, input sclk, output serial_data_out, output serial_data_oe);
  modport host (output select_n, output sclk, input serial_data_out_wire);
endinterface

// [adsc_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module adsc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  assign in_ready = (wr_reg - rd_reg) != (AW + 1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data = mem[rd_reg[AW-1:0]];

  // Storage and pointers
  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_reg + (AW + 1)'(do_wr);
      rd_reg <= rd_reg + (AW + 1)'(do_rd);
    end
  end
endmodule

// [adsc_host.sv]
// Host end: makes select and serial clock, reads frames into a FIFO
`timescale 1ns/1ps
module adsc_host #(
  parameter int RESULT_W = adsc_pkg::RESULT_BITS,
  parameter int FIFO_DEPTH = 16,
  parameter int HALF = adsc_pkg::SCLK_HALF_CYCLES,
  parameter int PERIOD_SCLK = adsc_pkg::SAMPLE_PERIOD_SCLK
) (
  input wire logic clock,
  input wire logic rst,
  adsc_if.host link,
  input wire logic run,
  input wire logic power_down_req,
  output logic [RESULT_W-1:0] sample_data,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic busy
);
  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  adsc_pkg::adsc_host_state_t st_reg;
  adsc_pkg::adsc_host_state_t st_next;
  logic [7:0] div_reg;
  logic [4:0] clk_cnt_reg;
  logic [7:0] period_reg;
  logic [15:0] rx_reg;
  logic short_reg;
  logic push_reg;
  logic lead_reg;
  logic drop_reg;

  logic [2:0] din_sync_reg;
  logic din_reg;
  wire fifo_ready;
  wire half_done = div_reg == 8'(HALF - 1);
  wire [4:0] burst = short_reg ? adsc_pkg::SHORT_BURST : adsc_pkg::DONE_EDGE;
  wire start_ok = run && fifo_ready && period_reg == 8'h00;

  // Data pin sampler
  always_ff @(posedge clock) begin
    din_sync_reg <= {din_sync_reg[1:0], link.serial_data_out_wire};
    if (din_sync_reg[1] == din_sync_reg[2]) din_reg <= din_sync_reg[2];
  end

  // Next state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      adsc_pkg::HST_IDLE: if (start_ok) st_next = adsc_pkg::HST_LOW;
      adsc_pkg::HST_LOW: if (half_done) st_next = adsc_pkg::HST_HIGH;
      adsc_pkg::HST_HIGH: begin
        if (half_done) st_next = (clk_cnt_reg == burst) ? adsc_pkg::HST_END : adsc_pkg::HST_LOW;
      end
      adsc_pkg::HST_END: st_next = adsc_pkg::HST_QUIET;
      adsc_pkg::HST_QUIET: if (div_reg == 8'(adsc_pkg::QUIET_CYCLES)) st_next = adsc_pkg::HST_IDLE;
      default: st_next = adsc_pkg::HST_IDLE;
    endcase
  end

  // Sequencer registers; clock falls at each HIGH->LOW step
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= adsc_pkg::HST_IDLE;
      div_reg <= 8'h00;
      clk_cnt_reg <= 5'h00;
      period_reg <= 8'h00;
      short_reg <= 1'b0;
      rx_reg <= 16'h0000;
      push_reg <= 1'b0;
      lead_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      push_reg <= 1'b0;
      div_reg <= (st_next != st_reg) ? 8'h00 : div_reg + 8'h01;
      // Free-running frame timer: starts fall on whole clock periods
      period_reg <= (period_reg == 8'h00) ? 8'(PERIOD_SCLK * 2 * HALF - 1) : period_reg - 8'h01;
      if (st_reg == adsc_pkg::HST_IDLE && start_ok) begin
        clk_cnt_reg <= 5'h00;
        short_reg <= power_down_req;
        lead_reg <= 1'b1;
      end
      // Rising edge: count clock, capture bit
      if (st_reg == adsc_pkg::HST_LOW && half_done) begin
        if (lead_reg) begin
          lead_reg <= 1'b0; // Lead-in half: clock held high after select fall
        end else begin
          clk_cnt_reg <= clk_cnt_reg + 5'h01;
          rx_reg <= {rx_reg[14:0], din_reg};
        end
      end
      if (st_reg == adsc_pkg::HST_END) begin
        if (!short_reg && !drop_reg) push_reg <= 1'b1;
        drop_reg <= short_reg; // Frame after a short burst is the dummy
      end
    end
  end

  assign link.select_n = st_reg == adsc_pkg::HST_IDLE || st_reg == adsc_pkg::HST_QUIET || st_reg == adsc_pkg::HST_END;
  assign link.sclk = !(st_reg == adsc_pkg::HST_LOW && !lead_reg);
  assign busy = st_reg != adsc_pkg::HST_IDLE;

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  adsc_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_data(rx_reg[RESULT_W-1:0]),
    .in_valid(push_reg),
    .in_ready(fifo_ready),
    .out_data(sample_data),
    .out_valid(sample_valid),
    .out_ready(sample_ready)
  );
endmodule

// [adsc_link_checker.sv]
// Assertion checker watching the signals of the converter link
`timescale 1ns/1ps
module adsc_link_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  logic sclk_d_reg;
  logic [4:0] falls_reg;
  logic [4:0] falls_next;

  // ----------------------------------------------------------------
  // Frame edge count
  // ----------------------------------------------------------------
  // Counts serial clock falls while selected, cleared when deselected
  assign falls_next = select_n ? 5'h00 : (sclk_d_reg && !sclk && falls_reg != 5'h1f) ? falls_reg + 5'h01 : falls_reg;
  always_ff @(posedge clock) begin
    sclk_d_reg <= sclk;
    falls_reg <= rst ? 5'h00 : falls_next;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_drive_on_select: assert property ($fell(select_n) |-> ##[1:6] serial_data_oe)
    else $error("output not driven after select fall");
  a_first_zero: assert property ($rose(serial_data_oe) |-> !serial_data_out)
    else $error("frame does not open with zero");
  a_leading_zeros: assert property (serial_data_oe && !select_n && falls_reg <= 5'h01 |-> !serial_data_out)
    else $error("leading zeros wrong");
  a_bit_steady_high: assert property (serial_data_oe && $past(serial_data_oe) && sclk && $past(sclk)
    |-> $stable(serial_data_out))
    else $error("data moved while serial clock high");
  a_oe_in_frame: assert property (!select_n && falls_reg inside {[5'h01:5'h0e]} |-> serial_data_oe)
    else $error("output dropped inside frame");
  a_release_after_last: assert property ($rose(falls_reg == 5'h10) |-> ##[1:6] !serial_data_oe)
    else $error("output not released after last fall");
  a_release_on_rise: assert property ($rose(select_n) |-> ##[1:6] !serial_data_oe)
    else $error("output not released on select rise");
  a_quiet_deselected: assert property (select_n [*6] |-> !serial_data_oe)
    else $error("output driven while deselected");
  a_burst_length: assert property ($rose(select_n) |-> falls_reg == 5'h10 || falls_reg == 5'h08)
    else $error("burst length not 16 or 8");
  a_quiet_gap: assert property ($rose(select_n) |=> select_n [*3])
    else $error("quiet gap too short");

  c_full_frame: cover property ($rose(select_n) && falls_reg == 5'h10);
  c_short_burst: cover property ($rose(select_n) && falls_reg == 5'h08);
  c_drive: cover property ($rose(serial_data_oe));
endmodule

// [tb_adc_serial_conversion_control.sv]
// Self-checking bench: host and converter joined, plus a hand-driven converter
`timescale 1ns/1ps
module tb_adc_serial_conversion_control;
  logic clock;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic power_down_req = 1'b0;
  logic sample_ready = 1'b0;
  logic [13:0] analog_code = 14'h0000;
  logic [13:0] code_b = 14'h0000;
  logic track_hold, powered_down, conv_valid, sample_valid, busy;
  logic hold_b, down_b, valid_b;
  logic [13:0] conv_result, sample_data, result_b;
  logic [14:0] bits_b;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int valid_a = 0;
  int seen_b = 0;
  int pops = 0;
  int v;
  int p;
  int lens[8] = '{16, 1, 2, 9, 16, 16, 10, 16};
  logic downs[8] = '{0, 0, 1, 1, 0, 0, 0, 0};
  int incs[8] = '{1, 0, 0, 0, 0, 1, 0, 1};

  adsc_if i_link();
  adsc_if i_link_b();
  adsc_device i_adsc_device (.clock(clock), .rst(rst), .link(i_link.device), .analog_code(analog_code),
    .track_hold(track_hold), .powered_down(powered_down), .conv_valid(conv_valid), .conv_result(conv_result));
  adsc_host i_adsc_host (.clock(clock), .rst(rst), .link(i_link.host), .run(run), .power_down_req(power_down_req),
    .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready), .busy(busy));
  adsc_device i_adsc_device_b (.clock(clock), .rst(rst), .link(i_link_b.device), .analog_code(code_b),
    .track_hold(hold_b), .powered_down(down_b), .conv_valid(valid_b), .conv_result(result_b));
  adsc_link_checker i_adsc_link_checker (.clock(clock), .rst(rst), .select_n(i_link.select_n),
    .sclk(i_link.sclk), .serial_data_out(i_link.serial_data_out), .serial_data_oe(i_link.serial_data_oe));

  // Clock of 100 ns
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Result counters and hang limit
  always @(posedge clock) begin
    cycles++;
    if (conv_valid === 1'b1) valid_a++;
    if (valid_b === 1'b1) seen_b++;
    if (sample_valid === 1'b1 && sample_ready === 1'b1) pops++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  function automatic logic [13:0] code_of(input int k);
    return 14'h3fff ^ (k[13:0] * 14'h0421);
  endfunction

  task automatic check(input logic ok, input string what);
    total_checks++;
    if (!ok) begin
      failures++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic wait_sig(ref logic s, input logic lvl, input int lim);
    for (int i = 0; i < lim && s !== lvl; i++) @(negedge clock);
    check(s === lvl, "timeout waiting");
  endtask

  // Hand-driven frame of n serial clocks on the second link, capture on rises
  task automatic frame_b(input int n);
    bits_b = '0;
    i_link_b.select_n = 1'b0;
    repeat (6) @(negedge clock);
    check(i_link_b.serial_data_out_wire === 1'b0, "first zero missing");
    check(hold_b === 1'b1, "not in hold");
    for (int k = 1; k <= n; k++) begin
      i_link_b.sclk = 1'b0;
      repeat (4) @(negedge clock);
      i_link_b.sclk = 1'b1;
      repeat (2) @(negedge clock);
      if (k <= 15) bits_b = {bits_b[13:0], i_link_b.serial_data_out_wire};
      repeat (2) @(negedge clock);
    end
    if (n >= 16) check(hold_b === 1'b0, "not back in track");
    i_link_b.select_n = 1'b1;
    repeat (10) @(negedge clock);
    check(i_link_b.serial_data_oe === 1'b0 && i_link_b.serial_data_out_wire === 1'b1, "output not released");
  endtask

  task automatic test_done;
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    i_link_b.select_n = 1'b1;
    i_link_b.sclk = 1'b1;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    run = 1'b1;
    // Fill the FIFO with 16 frames while the reader stalls
    for (int k = 0; k < 16; k++) begin
      analog_code = code_of(k);
      wait_sig(conv_valid, 1'b1, 400);
      check(conv_result === code_of(k), "conversion result");
      @(negedge clock);
    end
    repeat (500) @(negedge clock);
    check(valid_a === 16 && sample_valid === 1'b1, "full FIFO did not stall frames");
    for (int k = 0; k < 16; k++) begin
      wait_sig(sample_valid, 1'b1, 50);
      check(sample_data === code_of(k), "frame word");
      sample_ready = 1'b1;
      @(negedge clock);
      sample_ready = 1'b0;
    end
    check(sample_valid === 1'b0, "FIFO not empty");
    // Short burst, then wake-up dummy frame
    sample_ready = 1'b1;
    power_down_req = 1'b1;
    wait_sig(powered_down, 1'b1, 800);
    power_down_req = 1'b0;
    wait_sig(powered_down, 1'b0, 800);
    v = valid_a;
    p = pops;
    repeat (100) @(negedge clock);
    check(valid_a === v, "dummy frame marked valid");
    check(pops === p, "dummy frame reached the FIFO");
    wait_sig(conv_valid, 1'b1, 400);
    run = 1'b0;
    // Aborts and power windows on the hand-driven link
    for (int k = 0; k < 8; k++) begin
      code_b = {7{k[0], ~k[0]}};
      v = seen_b;
      frame_b(lens[k]);
      check(down_b === downs[k], "power mode");
      check(seen_b === v + incs[k], "result count");
      if (incs[k] == 1) check(result_b === code_b && bits_b === {1'b0, code_b}, "frame bits");
    end
    test_done();
  end
endmodule
